//--- hw/shared_memory_slave_port.sv
// shared memory slave port core: host latches, flags, control and status
`default_nettype none
module shared_memory_slave_port #(
   parameter int DAT_W = smsp_pkg::DATA_W
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [smsp_pkg::SFR_AW-1:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [smsp_pkg::DATA_W-1:0] sfr_wdata,
   output logic [smsp_pkg::DATA_W-1:0] sfr_rdata,
   input wire logic [smsp_pkg::IRQ_N-1:0] irq_mask,
   input wire logic [smsp_pkg::DATA_W-1:0] host_ad_i,
   output logic [smsp_pkg::DATA_W-1:0] host_ad_o,
   output logic host_ad_oe,
   input wire logic host_addr_latch_strobe,
   input wire logic host_read_strobe_n,
   input wire logic host_write_strobe_n,
   input wire logic host_select_n,
   output logic host_attention_out,
   output logic command_full_irq,
   output logic write_latch_full_irq,
   output logic read_latch_empty_irq
);
   import smsp_pkg::*;

   // the latches are byte wide by construction
   if (DAT_W != DATA_W) begin : g_width_check
      $error("shared_memory_slave_port supports only byte-wide data");
   end

   // whole core state in one record
   typedef struct packed {
      logic [DATA_W-1:0] ctl; // port_control_reg
      logic [STAT_USER_W-1:0] user; // valid_marker_bit and user_status_field
      logic command_empty_flag;
      logic write_latch_empty_flag;
      logic read_latch_full_flag;
      logic [DATA_W-1:0] host_command_latch;
      logic [DATA_W-1:0] host_write_data_latch;
      logic [DATA_W-1:0] host_read_data_latch;
      logic [DATA_W-1:0] pend_addr; // low address byte from last strobe fall
      logic shared_attn; // attention state in shared mode
      logic attn;
      logic [DATA_W-1:0] ad_out;
      logic ad_oe;
      logic [IRQ_N-1:0] irq;
      logic [DATA_W-1:0] rdata;
   } port_state_t;

   localparam port_state_t PORT_RST = '{
      ctl: CTL_RST, user: STAT_USER_RST,
      command_empty_flag: 1'b0, write_latch_empty_flag: 1'b0,
      read_latch_full_flag: 1'b0,
      host_command_latch: BYTE_ZERO, host_write_data_latch: BYTE_ZERO,
      host_read_data_latch: BYTE_ZERO, pend_addr: BYTE_ZERO,
      shared_attn: 1'b0, attn: 1'b0, ad_out: BYTE_ZERO, ad_oe: 1'b0,
      irq: '0, rdata: BYTE_ZERO
   };

   port_state_t q, d;
   host_op_t op; // host access finishing this cycle
   logic host_sel; // register_select_internal during that access

   host_evt_if evt ();

   // pin synchronisers and strobe edge detection
   host_pin_sync u_sync (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .host_ad_i(host_ad_i),
      .host_addr_latch_strobe(host_addr_latch_strobe),
      .host_read_strobe_n(host_read_strobe_n),
      .host_write_strobe_n(host_write_strobe_n),
      .host_select_n(host_select_n),
      .evt(evt)
   );

   // status byte as seen by both host and slave
   function automatic logic [DATA_W-1:0] status_byte(input port_state_t st);
      return {st.user, st.command_empty_flag, st.write_latch_empty_flag,
              st.read_latch_full_flag};
   endfunction

   // register_select_internal: zero in shared mode, else pin or address bit
   function automatic logic reg_select(input port_state_t st, input logic ale_lvl);
      if (st.ctl[CTL_MODE]) begin
         return 1'b0;
      end
      return st.ctl[CTL_SRC] ? st.pend_addr[SEL_ADDR_BIT] : ale_lvl;
   endfunction

   // next state: host side first, slave side after so its sets win
   always_comb begin
      d = q;
      d.irq = '0;
      op = OP_NONE;
      host_sel = reg_select(q, evt.ale_lvl);
      // capture the multiplexed low address on every strobe fall
      if (evt.ale_fall) begin
         d.pend_addr = evt.ad;
      end
      // only a selected access on an enabled port counts
      if (q.ctl[CTL_EN] && evt.cs_act) begin
         if (evt.rd_rise) begin
            op = OP_READ;
         end else if (evt.wr_rise) begin
            op = OP_WRITE;
         end
      end
      unique case (op)
         OP_NONE: begin
         end
         OP_READ: begin
            // status reads have no side effect
            if (!host_sel) begin
               d.read_latch_full_flag = 1'b0;
               d.shared_attn = 1'b0;
               if (q.ctl[CTL_MODE]) begin
                  // window address starts the next fetch
                  d.host_command_latch = q.pend_addr;
                  d.irq[IRQ_RD_EMPTY] = 1'b1;
               end
            end
         end
         OP_WRITE: begin
            if (q.ctl[CTL_MODE]) begin
               // one cycle carries address and data; read latch kept
               d.host_command_latch = q.pend_addr;
               d.host_write_data_latch = evt.ad;
               d.write_latch_empty_flag = 1'b0;
               d.shared_attn = 1'b0;
               d.irq[IRQ_WR_FULL] = 1'b1;
            end else if (host_sel) begin
               // status is read-only to the host
               d.host_command_latch = evt.ad;
               d.command_empty_flag = 1'b0;
               d.irq[IRQ_CMD_FULL] = 1'b1;
            end else begin
               d.host_write_data_latch = evt.ad;
               d.write_latch_empty_flag = 1'b0;
               d.irq[IRQ_WR_FULL] = 1'b1;
            end
         end
      endcase
      // slave register reads and their side effects
      if (sfr_rd) begin
         unique case (sfr_addr)
            ADDR_STATUS: d.rdata = status_byte(q);
            ADDR_CONTROL: d.rdata = q.ctl & CTL_RW_MASK;
            ADDR_CMD: begin
               d.rdata = q.host_command_latch;
               d.command_empty_flag = 1'b1;
            end
            ADDR_WR_DATA: begin
               d.rdata = q.host_write_data_latch;
               d.write_latch_empty_flag = 1'b1;
               d.shared_attn = 1'b1;
            end
            ADDR_RD_DATA: d.rdata = q.host_read_data_latch;
            default: d.rdata = BYTE_ZERO;
         endcase
      end
      // slave register writes
      if (sfr_wr) begin
         unique case (sfr_addr)
            ADDR_STATUS: begin
               // flags stay hardware owned
               d.user = sfr_wdata[DATA_W-1:STAT_USER_LSB];
            end
            ADDR_CONTROL: d.ctl = sfr_wdata & CTL_RW_MASK;
            ADDR_CMD: begin
               d.host_command_latch = sfr_wdata;
               d.command_empty_flag = 1'b1;
            end
            ADDR_WR_DATA: begin
               d.host_write_data_latch = sfr_wdata;
               d.write_latch_empty_flag = 1'b1;
            end
            ADDR_RD_DATA: begin
               d.host_read_data_latch = sfr_wdata;
               d.read_latch_full_flag = 1'b1;
               d.shared_attn = 1'b1;
            end
            default: begin
            end
         endcase
      end
      // a disabled port holds its flags cleared
      if (!d.ctl[CTL_EN]) begin
         d.command_empty_flag = 1'b0;
         d.write_latch_empty_flag = 1'b0;
         d.read_latch_full_flag = 1'b0;
         d.shared_attn = 1'b0;
      end
      // attention: event driven in shared mode, masked flags otherwise
      if (!d.ctl[CTL_EN]) begin
         d.attn = 1'b0;
      end else if (d.ctl[CTL_MODE]) begin
         d.attn = d.shared_attn;
      end else begin
         d.attn = (d.write_latch_empty_flag & d.ctl[CTL_WE_MASK])
                | (d.read_latch_full_flag & d.ctl[CTL_RF_MASK]);
      end
      // drive the bus while a selected read is in progress
      d.ad_oe = q.ctl[CTL_EN] & evt.rd_act & evt.cs_act;
      d.ad_out = host_sel ? status_byte(q) : q.host_read_data_latch;
      d.irq = d.irq & irq_mask;
   end

   // state register
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         q <= PORT_RST;
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state register
   assign sfr_rdata = q.rdata;
   assign host_ad_o = q.ad_out;
   assign host_ad_oe = q.ad_oe;
   assign host_attention_out = q.attn;
   assign command_full_irq = q.irq[IRQ_CMD_FULL];
   assign write_latch_full_irq = q.irq[IRQ_WR_FULL];
   assign read_latch_empty_irq = q.irq[IRQ_RD_EMPTY];

   // shared mode host access with no slave access beside it
   sequence s_shared_write;
      op == OP_WRITE && q.ctl[CTL_MODE] && !sfr_wr && !sfr_rd;
   endsequence
   sequence s_shared_read;
      op == OP_READ && q.ctl[CTL_MODE] && !sfr_wr && !sfr_rd;
   endsequence

   property p_shared_write_cmd;
      @(posedge clk_sys) disable iff (sys_rst)
      s_shared_write |=> q.host_command_latch == $past(q.pend_addr)
         && q.host_write_data_latch == $past(evt.ad) && !q.write_latch_empty_flag;
   endproperty
   a_shared_write_cmd: assert property (p_shared_write_cmd) else $error("write not latched");

   property p_write_keeps_read;
      @(posedge clk_sys) disable iff (sys_rst)
      (op == OP_WRITE && !sfr_wr) |=> $stable(q.host_read_data_latch)
         && q.read_latch_full_flag == $past(q.read_latch_full_flag);
   endproperty
   a_write_keeps_read: assert property (p_write_keeps_read) else $error("read latch hit");

   property p_read_drops_attn;
      @(posedge clk_sys) disable iff (sys_rst)
      s_shared_read |=> !q.attn && !q.read_latch_full_flag
         && read_latch_empty_irq == $past(irq_mask[IRQ_RD_EMPTY]);
   endproperty
   a_read_drops_attn: assert property (p_read_drops_attn) else $error("read effects wrong");

   property p_slave_fill_attn;
      @(posedge clk_sys) disable iff (sys_rst)
      (sfr_wr && sfr_addr == ADDR_RD_DATA && q.ctl[CTL_EN] && q.ctl[CTL_MODE])
         |=> q.attn && q.read_latch_full_flag && q.host_read_data_latch == $past(sfr_wdata);
   endproperty
   a_slave_fill_attn: assert property (p_slave_fill_attn) else $error("fill no attention");

   property p_slave_drain_attn;
      @(posedge clk_sys) disable iff (sys_rst)
      (sfr_rd && sfr_addr == ADDR_WR_DATA && q.ctl[CTL_EN] && q.ctl[CTL_MODE] && !sfr_wr)
         |=> q.attn && q.write_latch_empty_flag && sfr_rdata == $past(q.host_write_data_latch);
   endproperty
   a_slave_drain_attn: assert property (p_slave_drain_attn) else $error("drain no attention");

   property p_disable_clears;
      @(posedge clk_sys) disable iff (sys_rst)
      !q.ctl[CTL_EN] |-> {q.command_empty_flag, q.write_latch_empty_flag,
         q.read_latch_full_flag} == 3'b000 && !host_attention_out;
   endproperty
   a_disable_clears: assert property (p_disable_clears) else $error("flags set when off");

   property p_std_attention;
      @(posedge clk_sys) disable iff (sys_rst)
      (q.ctl[CTL_EN] && !q.ctl[CTL_MODE]) |-> host_attention_out ==
         ((q.write_latch_empty_flag && q.ctl[CTL_WE_MASK])
          || (q.read_latch_full_flag && q.ctl[CTL_RF_MASK]));
   endproperty
   a_std_attention: assert property (p_std_attention) else $error("attention mask wrong");

   property p_ctl_reserved;
      @(posedge clk_sys) disable iff (sys_rst) q.ctl[DATA_W-1:CTL_MODE+1] == 3'b000;
   endproperty
   a_ctl_reserved: assert property (p_ctl_reserved) else $error("reserved bits set");

   property p_status_write;
      @(posedge clk_sys) disable iff (sys_rst)
      (sfr_wr && sfr_addr == ADDR_STATUS) |=>
         q.user == $past(sfr_wdata[DATA_W-1:STAT_USER_LSB]);
   endproperty
   a_status_write: assert property (p_status_write) else $error("status write lost");

   property p_cmd_write_std;
      @(posedge clk_sys) disable iff (sys_rst)
      (op == OP_WRITE && !q.ctl[CTL_MODE] && host_sel && !sfr_wr && !sfr_rd)
         |=> !q.command_empty_flag && q.host_command_latch == $past(evt.ad)
         && command_full_irq == $past(irq_mask[IRQ_CMD_FULL]);
   endproperty
   a_cmd_write_std: assert property (p_cmd_write_std) else $error("command write wrong");
endmodule
`default_nettype wire

//--- hw/smsp_pkg.sv
// constants and types shared by the shared memory slave port design
`default_nettype none
package smsp_pkg;
   // byte width of the host bus and of every latch
   localparam int DATA_W = 8;
   localparam int SFR_AW = 16;
   // slave-side register byte addresses
   localparam logic [SFR_AW-1:0] ADDR_STATUS = 16'h1ff8;
   localparam logic [SFR_AW-1:0] ADDR_WR_DATA = 16'h1ff9;
   localparam logic [SFR_AW-1:0] ADDR_CMD = 16'h1ffa;
   localparam logic [SFR_AW-1:0] ADDR_CONTROL = 16'h1ffb;
   localparam logic [SFR_AW-1:0] ADDR_RD_DATA = 16'h1ffc;
   // control register bit positions
   localparam int CTL_MODE = 4;
   localparam int CTL_EN = 3;
   localparam int CTL_SRC = 2;
   localparam int CTL_WE_MASK = 1;
   localparam int CTL_RF_MASK = 0;
   // writable control bits, reserved 7:5 read zero
   localparam logic [DATA_W-1:0] CTL_RW_MASK = 8'h1f;
   localparam logic [DATA_W-1:0] CTL_RST = 8'h00;
   // status register layout
   localparam int STAT_USER_LSB = 3;
   localparam int STAT_USER_W = 5;
   localparam logic [STAT_USER_W-1:0] STAT_USER_RST = 5'h00;
   // address bit that selects status/command on a multiplexed bus
   localparam int SEL_ADDR_BIT = 1;
   // interrupt request indices
   localparam int IRQ_CMD_FULL = 0;
   localparam int IRQ_WR_FULL = 1;
   localparam int IRQ_RD_EMPTY = 2;
   localparam int IRQ_N = 3;
   localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
   // decoded host bus operation
   typedef enum logic [1:0] {
      OP_NONE = 2'b00,
      OP_READ = 2'b01,
      OP_WRITE = 2'b10
   } host_op_t;
endpackage
`default_nettype wire

//--- hw/host_evt_if.sv
// synchronised host strobe events passed from the pin stage to the port core
`default_nettype none
interface host_evt_if;
   logic ale_fall; // pulse: address strobe fell
   logic rd_rise; // pulse: read strobe ended
   logic wr_rise; // pulse: write strobe ended
   logic ale_lvl; // level of the address strobe pin
   logic rd_act; // read strobe active
   logic cs_act; // chip select active
   logic [smsp_pkg::DATA_W-1:0] ad; // bus byte held before the edge
   modport src (output ale_fall, rd_rise, wr_rise, ale_lvl, rd_act, cs_act, ad);
   modport dst (input ale_fall, rd_rise, wr_rise, ale_lvl, rd_act, cs_act, ad);
endinterface
`default_nettype wire

//--- hw/host_pin_sync.sv
// two-flop synchronisers and edge detection for the host bus pins
`default_nettype none
module host_pin_sync (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [smsp_pkg::DATA_W-1:0] host_ad_i,
   input wire logic host_addr_latch_strobe,
   input wire logic host_read_strobe_n,
   input wire logic host_write_strobe_n,
   input wire logic host_select_n,
   host_evt_if.src evt
);
   import smsp_pkg::*;

   // all pin stage state; index 0 is the first synchroniser flop
   typedef struct packed {
      logic [1:0] ale_s;
      logic [1:0] rd_s;
      logic [1:0] wr_s;
      logic [1:0] cs_s;
      logic [DATA_W-1:0] ad_s1;
      logic [DATA_W-1:0] ad_s2;
      logic ale_p; // previous settled levels
      logic rd_p;
      logic wr_p;
      logic cs_p;
      logic [DATA_W-1:0] ad_p;
      logic ale_fall;
      logic rd_rise;
      logic wr_rise;
      logic ale_lvl;
      logic rd_act;
      logic cs_act;
      logic [DATA_W-1:0] ad;
   } sync_state_t;

   // strobes idle high except the address strobe
   localparam sync_state_t SYNC_RST = '{
      ale_s: 2'b00, rd_s: 2'b11, wr_s: 2'b11, cs_s: 2'b11,
      ad_s1: BYTE_ZERO, ad_s2: BYTE_ZERO,
      ale_p: 1'b0, rd_p: 1'b1, wr_p: 1'b1, cs_p: 1'b1, ad_p: BYTE_ZERO,
      ale_fall: 1'b0, rd_rise: 1'b0, wr_rise: 1'b0,
      ale_lvl: 1'b0, rd_act: 1'b0, cs_act: 1'b0, ad: BYTE_ZERO
   };

   sync_state_t q, d;

   // next state: shift synchronisers, detect edges on settled copies
   always_comb begin
      d = q;
      d.ale_s = {q.ale_s[0], host_addr_latch_strobe};
      d.rd_s = {q.rd_s[0], host_read_strobe_n};
      d.wr_s = {q.wr_s[0], host_write_strobe_n};
      d.cs_s = {q.cs_s[0], host_select_n};
      d.ad_s1 = host_ad_i;
      d.ad_s2 = q.ad_s1;
      d.ale_p = q.ale_s[1];
      d.rd_p = q.rd_s[1];
      d.wr_p = q.wr_s[1];
      d.cs_p = q.cs_s[1];
      d.ad_p = q.ad_s2;
      // edges compare the second flop with its own previous value
      d.ale_fall = q.ale_p & ~q.ale_s[1];
      d.rd_rise = ~q.rd_p & q.rd_s[1];
      d.wr_rise = ~q.wr_p & q.wr_s[1];
      d.ale_lvl = q.ale_s[1];
      d.rd_act = ~q.rd_s[1];
      // select and data as they stood just before the edge
      d.cs_act = ~q.cs_p;
      d.ad = q.ad_p;
   end

   // state register
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         q <= SYNC_RST;
      end else begin
         q <= d;
      end
   end

   assign evt.ale_fall = q.ale_fall;
   assign evt.rd_rise = q.rd_rise;
   assign evt.wr_rise = q.wr_rise;
   assign evt.ale_lvl = q.ale_lvl;
   assign evt.rd_act = q.rd_act;
   assign evt.cs_act = q.cs_act;
   assign evt.ad = q.ad;

   // a strobe edge is one cycle long
   property p_rd_rise_pulse;
      @(posedge clk_sys) disable iff (sys_rst) q.rd_rise |=> !q.rd_rise;
   endproperty
   a_rd_rise_pulse: assert property (p_rd_rise_pulse) else $error("read rise held");
endmodule
`default_nettype wire

//--- sim/host_master_model.sv
// behavioural master processor driving the multiplexed host bus
`default_nettype none
module host_master_model (
   input wire logic clk_sys,
   input wire logic [7:0] dev_ad,
   input wire logic dev_oe,
   output logic ale,
   output logic rd_n,
   output logic wr_n,
   output logic cs_n,
   output logic [7:0] ad
);
   timeunit 1ns;
   timeprecision 100ps;
   logic drv_en; // master drives the byte lanes
   logic [7:0] drv_val; // byte the master drives
   logic [7:0] last_val; // last level seen on the lanes
   // undriven lanes flip every cycle so stale data never looks valid
   assign ad = dev_oe ? dev_ad : (drv_en ? drv_val : ~last_val);
   // remember the wire level for the undriven pattern
   always @(posedge clk_sys) begin
      last_val <= ad;
   end
   // idle bus: nothing selected, read and write strobes high, address strobe low
   initial begin
      last_val = 8'h00;
      drv_en = 1'b0;
      drv_val = 8'h00;
      cs_n = 1'b1;
      ale = 1'b0;
      rd_n = 1'b1;
      wr_n = 1'b1;
   end
   // one complete bus cycle: address phase, then a single strobe
   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
      output logic [7:0] rdata);
      @(negedge clk_sys);
      cs_n = 1'b0;
      ale = 1'b1;
      drv_en = 1'b1;
      drv_val = addr;
      repeat (4) @(negedge clk_sys);
      ale = 1'b0;
      repeat (3) @(negedge clk_sys);
      drv_en = wr;
      drv_val = wdata;
      rd_n = wr;
      wr_n = !wr;
      repeat (6) @(negedge clk_sys);
      rdata = ad;
      rd_n = 1'b1;
      wr_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      drv_en = 1'b0;
      cs_n = 1'b1;
      repeat (8) @(negedge clk_sys);
   endtask
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench for the shared memory slave port
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import smsp_pkg::*;
   logic clk_sys;
   logic sys_rst;
   logic [15:0] sfr_addr;
   logic sfr_wr;
   logic sfr_rd;
   logic [7:0] sfr_wdata;
   logic [7:0] sfr_rdata;
   logic [2:0] irq_mask;
   logic [7:0] ad;
   logic [7:0] ad_o;
   logic ad_oe;
   logic ale;
   logic rd_n;
   logic wr_n;
   logic cs_n;
   logic att;
   wire [2:0] irq; // cmd full, write full, read empty
   logic [7:0] cnt_cmd;
   logic [7:0] cnt_wr;
   logic [7:0] cnt_rde;
   int miscompares = 0;
   int samples_checked = 0;
   shared_memory_slave_port dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .irq_mask(irq_mask), .host_ad_i(ad), .host_ad_o(ad_o), .host_ad_oe(ad_oe),
      .host_addr_latch_strobe(ale), .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n),
      .host_select_n(cs_n), .host_attention_out(att), .command_full_irq(irq[0]),
      .write_latch_full_irq(irq[1]), .read_latch_empty_irq(irq[2]));
   host_master_model host (.clk_sys(clk_sys), .dev_ad(ad_o), .dev_oe(ad_oe), .ale(ale),
      .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n), .ad(ad));
   // 125 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // count one-cycle interrupt pulses
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         cnt_cmd <= 8'h00;
         cnt_wr <= 8'h00;
         cnt_rde <= 8'h00;
      end else begin
         cnt_cmd <= cnt_cmd + {7'h00, irq[0]};
         cnt_wr <= cnt_wr + {7'h00, irq[1]};
         cnt_rde <= cnt_rde + {7'h00, irq[2]};
      end
   end
   // verdict and end of run
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // byte comparison
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // slave register write, one-cycle strobe
   task automatic sfr_write(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk_sys);
      sfr_wr = 1'b0;
   endtask
   // slave register read and compare under a mask
   task automatic expect_reg(input logic [15:0] a, input logic [7:0] exp,
      input logic [7:0] m = 8'hff);
      @(negedge clk_sys);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk_sys);
      sfr_rd = 1'b0;
      check8(sfr_rdata & m, exp);
   endtask
   // bounded wait for attention high
   task automatic wait_att;
      int n;
      n = 0;
      while (att !== 1'b1 && n < 40) begin
         @(negedge clk_sys);
         n++;
      end
      check8({7'h00, att}, 8'h01);
      if (att !== 1'b1) begin
         complete_run();
      end
   endtask
   // main sequence
   initial begin
      logic [7:0] d;
      sys_rst = 1'b1;
      sfr_addr = 16'h0000;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_wdata = 8'h00;
      irq_mask = 3'h7;
      repeat (12) @(negedge clk_sys);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk_sys);
      expect_reg(ADDR_CONTROL, CTL_RST);
      expect_reg(16'h1ff0, BYTE_ZERO);
      sfr_write(ADDR_CONTROL, 8'hff);
      expect_reg(ADDR_CONTROL, CTL_RW_MASK);
      // shared mode initialisation
      sfr_write(ADDR_CONTROL, 8'h1b);
      sfr_write(ADDR_RD_DATA, 8'hff);
      sfr_write(ADDR_CMD, BYTE_ZERO);
      sfr_write(ADDR_WR_DATA, BYTE_ZERO);
      expect_reg(ADDR_STATUS, 8'h07);
      sfr_write(ADDR_STATUS, 8'hac);
      expect_reg(ADDR_STATUS, 8'haf);
      wait_att();
      host.access(1'b0, 8'h42, 8'h00, d);
      check8(d, 8'hff);
      check8({7'h00, ad_oe}, 8'h00);
      check8({7'h00, att}, 8'h00);
      check8(cnt_rde, 8'h01);
      expect_reg(ADDR_CMD, 8'h42);
      expect_reg(ADDR_STATUS, 8'haa, 8'hfb);
      sfr_write(ADDR_RD_DATA, 8'h99);
      wait_att();
      host.access(1'b1, 8'h10, 8'h66, d);
      check8({7'h00, att}, 8'h00);
      check8(cnt_wr, 8'h01);
      expect_reg(ADDR_STATUS, 8'ha9, 8'hfb);
      expect_reg(ADDR_RD_DATA, 8'h99);
      expect_reg(ADDR_CMD, 8'h10);
      expect_reg(ADDR_WR_DATA, 8'h66);
      wait_att();
      host.access(1'b0, 8'h43, 8'h00, d);
      check8(d, 8'h99);
      // disable clears flags and refuses host strobes
      sfr_write(ADDR_CONTROL, 8'h00);
      expect_reg(ADDR_STATUS, 8'ha8);
      check8({7'h00, att}, 8'h00);
      host.access(1'b1, 8'h11, 8'h55, d);
      check8(cnt_wr, 8'h01);
      // standard mode, select taken from address bit 1
      sfr_write(ADDR_CONTROL, 8'h0d);
      host.access(1'b1, 8'h02, 8'h77, d);
      check8(cnt_cmd, 8'h01);
      expect_reg(ADDR_CMD, 8'h77);
      sfr_write(ADDR_RD_DATA, 8'h31);
      wait_att();
      host.access(1'b0, 8'h02, 8'h00, d);
      check8(d, 8'had);
      host.access(1'b0, 8'h02, 8'h00, d);
      check8(d, 8'had);
      host.access(1'b0, 8'h00, 8'h00, d);
      check8(d, 8'h31);
      check8({7'h00, att}, 8'h00);
      irq_mask = 3'h5;
      host.access(1'b1, 8'h00, 8'h21, d);
      check8(cnt_wr, 8'h01);
      sfr_write(ADDR_CONTROL, 8'h0a);
      expect_reg(ADDR_WR_DATA, 8'h21);
      wait_att();
      // select from the address strobe pin: low at strobe end, data latch
      host.access(1'b1, 8'h02, 8'h5a, d);
      check8({7'h00, att}, 8'h00);
      check8(cnt_cmd, 8'h01);
      expect_reg(ADDR_WR_DATA, 8'h5a);
      complete_run();
   end
endmodule
`default_nettype wire
